// *** design/fbx_exec.sv ***
`timescale 1ns/10ps
module fbx_exec (
    input  wire logic                          core_clk,
    input  wire logic                          reset_n,
    input  wire logic [15:0]                   instr,
    input  wire logic                          instr_valid,
    input  wire fbx_pkg::fbx_flags_t           flags,
    input  wire logic                          ext_set_enable,
    input  wire logic [3:0]                    bank_select_register,
    input  wire logic [fbx_pkg::FADDR_W-1:0]   index_base,
    input  wire logic [fbx_pkg::PC_W-1:0]      pc_incremented,
    input  wire logic [7:0]                    file_rdata,
    output logic [1:0]                         quarter,
    output logic                               pc_load,
    output logic [fbx_pkg::PC_W-1:0]           pc_target,
    output fbx_pkg::fbx_file_req_t             file_req,
    output logic                               flush
);
    localparam int PC_W_L = fbx_pkg::PC_W;

    fbx_pkg::fbx_state_t r;
    fbx_pkg::fbx_state_t next_r;
    logic [1:0]          q;
    logic                taken_now;
    logic [PC_W_L-1:0]   offset2;

    fbx_quarter_phase u_phase (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .quarter  (q)
    );

    always_comb begin
        next_r          = r;
        next_r.pc_load  = 1'b0;
        next_r.file.rd  = 1'b0;
        next_r.file.wr  = 1'b0;
        taken_now       = 1'b0;
        offset2         = {{(PC_W_L-9){r.lit[7]}}, r.lit, 1'b0};
        case (r.op)
            fbx_pkg::FBX_OP_BRANCH_IF_NEGATIVE:    taken_now = flags.negative;
            fbx_pkg::FBX_OP_BRANCH_IF_CARRY_CLEAR: taken_now = !flags.carry;
            fbx_pkg::FBX_OP_BRANCH_IF_NONNEGATIVE: taken_now = !flags.negative;
            fbx_pkg::FBX_OP_BRANCH_IF_NO_OVERFLOW: taken_now = !flags.overflow;
            default:                               taken_now = 1'b0;
        endcase
        case (q)
            fbx_pkg::Q_DECODE: begin
                next_r.op    = fbx_pkg::FBX_OP_NONE;
                next_r.taken = 1'b0;
                if (r.st == fbx_pkg::FBX_FLUSH) begin
                    // Second cycle of a taken branch idles
                    next_r.flush = 1'b1;
                    next_r.st    = fbx_pkg::FBX_RUN;
                end else begin
                    next_r.flush = 1'b0;
                    next_r.base  = pc_incremented;
                    if (instr_valid) begin
                        next_r.lit     = instr[7:0];
                        next_r.bit_idx = instr[fbx_pkg::BIT_IDX_LSB +: 3];
                        case (instr[15:8])
                            fbx_pkg::OPC_NEG:
                                next_r.op = fbx_pkg::FBX_OP_BRANCH_IF_NEGATIVE;
                            fbx_pkg::OPC_CARRY_CLR:
                                next_r.op = fbx_pkg::FBX_OP_BRANCH_IF_CARRY_CLEAR;
                            fbx_pkg::OPC_NONNEG:
                                next_r.op = fbx_pkg::FBX_OP_BRANCH_IF_NONNEGATIVE;
                            fbx_pkg::OPC_NO_OVF:
                                next_r.op = fbx_pkg::FBX_OP_BRANCH_IF_NO_OVERFLOW;
                            default: begin
                                if (instr[15:12] == fbx_pkg::OPC_BIT_CLEAR) begin
                                    next_r.op = fbx_pkg::FBX_OP_FILE_BIT_CLEAR;
                                end
                            end
                        endcase
                        // Address select for the bit clear
                        next_r.file.indexed = 1'b0;
                        if (instr[fbx_pkg::ACCESS_BIT]) begin
                            next_r.file.addr = {bank_select_register, instr[7:0]};
                        end else if (ext_set_enable && instr[7:0] <= fbx_pkg::INDEXED_LIMIT) begin
                            next_r.file.addr    = index_base + {4'h0, instr[7:0]};
                            next_r.file.indexed = 1'b1;
                        end else if (instr[7:0] <= fbx_pkg::INDEXED_LIMIT) begin
                            next_r.file.addr = {fbx_pkg::ACCESS_LO_BANK, instr[7:0]};
                        end else begin
                            next_r.file.addr = {fbx_pkg::ACCESS_HI_BANK, instr[7:0]};
                        end
                    end
                end
            end
            fbx_pkg::Q_READ: begin
                // Read file register or take the offset literal
                if (r.op == fbx_pkg::FBX_OP_FILE_BIT_CLEAR) begin
                    next_r.file.rd = 1'b1;
                end
            end
            fbx_pkg::Q_PROCESS: begin
                if (r.op == fbx_pkg::FBX_OP_FILE_BIT_CLEAR) begin
                    next_r.file.wdata = file_rdata & ~(8'h01 << r.bit_idx);
                end
                next_r.taken     = taken_now;
                next_r.pc_target = r.base + offset2;
            end
            fbx_pkg::Q_WRITE: begin
                if (r.op == fbx_pkg::FBX_OP_FILE_BIT_CLEAR) begin
                    next_r.file.wr = 1'b1;
                end
                // Not taken: nothing in Q4, no status write ever
                if (r.taken) begin
                    next_r.pc_load = 1'b1;
                    next_r.st      = fbx_pkg::FBX_FLUSH;
                end
            end
            default: begin
                next_r = r;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign quarter   = q;
    assign pc_load   = r.pc_load;
    assign pc_target = r.pc_target;
    assign file_req  = r.file;
    assign flush     = r.flush;
endmodule : fbx_exec

// *** design/fbx_pkg.sv ***
// What this block does
// - Opcode high byte 1110 0110 branches only when the negative flag is one.
// - Opcode high byte 1110 0011 branches only when the carry flag is zero.
// - Opcode high byte 1110 0111 branches only when the negative flag is zero.
// - Opcode high byte 1110 0101 branches only when the overflow flag is zero.
// - Taken target is incremented address plus twice the signed offset, -128 to 127.
// - One word; one instruction cycle if not taken, two if taken.
// - Taken: decode, read offset, process, write PC, then four idle phases.
// - Bit clear with access bit zero and extended set uses indexed mode for f<=95.
// - Opcode 1001 bbba clears bit b of the addressed file register only.
// - Access bit zero selects access bank; one uses bank select register bank.
package fbx_pkg;
    localparam int           PC_W           = 21;
    localparam int           FADDR_W        = 12;
    localparam logic [7:0]   OPC_NEG        = 8'he6;
    localparam logic [7:0]   OPC_CARRY_CLR  = 8'he3;
    localparam logic [7:0]   OPC_NONNEG     = 8'he7;
    localparam logic [7:0]   OPC_NO_OVF     = 8'he5;
    localparam logic [3:0]   OPC_BIT_CLEAR  = 4'h9;
    localparam int           BIT_IDX_LSB    = 9;
    localparam int           ACCESS_BIT     = 8;
    localparam logic [7:0]   INDEXED_LIMIT  = 8'h5f;
    localparam logic [3:0]   ACCESS_LO_BANK = 4'h0;
    localparam logic [3:0]   ACCESS_HI_BANK = 4'hf;
    localparam logic [1:0]   Q_DECODE       = 2'h0;
    localparam logic [1:0]   Q_READ         = 2'h1;
    localparam logic [1:0]   Q_PROCESS      = 2'h2;
    localparam logic [1:0]   Q_WRITE        = 2'h3;

    typedef enum logic [2:0] {
        FBX_OP_NONE,
        FBX_OP_BRANCH_IF_NEGATIVE,
        FBX_OP_BRANCH_IF_CARRY_CLEAR,
        FBX_OP_BRANCH_IF_NONNEGATIVE,
        FBX_OP_BRANCH_IF_NO_OVERFLOW,
        FBX_OP_FILE_BIT_CLEAR
    } fbx_op_t;

    typedef enum logic {
        FBX_RUN,
        FBX_FLUSH
    } fbx_exec_t;

    typedef struct packed {
        logic negative;
        logic overflow;
        logic carry;
    } fbx_flags_t;

    typedef struct packed {
        logic               rd;
        logic               wr;
        logic [FADDR_W-1:0] addr;
        logic [7:0]         wdata;
        logic               indexed;
    } fbx_file_req_t;

    typedef struct packed {
        logic [1:0] q;
    } fbx_phase_t;

    typedef struct packed {
        fbx_exec_t          st;
        fbx_op_t            op;
        logic [7:0]         lit;
        logic [2:0]         bit_idx;
        logic               taken;
        logic [PC_W-1:0]    base;
        logic               pc_load;
        logic [PC_W-1:0]    pc_target;
        fbx_file_req_t      file;
        logic               flush;
    } fbx_state_t;
endpackage : fbx_pkg

// *** design/fbx_quarter_phase.sv ***
`timescale 1ns/10ps
module fbx_quarter_phase (
    input  wire logic          core_clk,
    input  wire logic          reset_n,
    output logic [1:0]         quarter
);
    fbx_pkg::fbx_phase_t r;
    fbx_pkg::fbx_phase_t next_r;

    // Free running Q1..Q4 counter
    always_comb begin
        next_r   = r;
        next_r.q = r.q + 2'h1;
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign quarter = r.q;
endmodule : fbx_quarter_phase

// *** verification/fbx_exec_monitor.sv ***
`timescale 1ns/10ps
module fbx_exec_monitor (
    input wire logic                   core_clk,
    input wire logic                   reset_n,
    input wire logic [1:0]             quarter,
    input wire logic                   pc_load,
    input wire fbx_pkg::fbx_file_req_t file_req,
    input wire logic                   flush
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    sequence s_flush_run;
        flush [*4] ##1 !flush;
    endsequence
    sequence s_clear_tail;
        ##2 file_req.wr;
    endsequence
    AST_QUARTER_STEP: assert property ($past(reset_n) |-> quarter == 2'($past(quarter) + 2'h1))
        else $error("quarter did not advance by one");
    AST_FLUSH_LEN: assert property ($rose(flush) |-> s_flush_run)
        else $error("flush not four clocks long");
    AST_LOAD_FLUSH: assert property (pc_load |-> ##[1:4] $rose(flush))
        else $error("no idle cycle after pc load");
    AST_LOAD_PULSE: assert property (pc_load |=> !pc_load)
        else $error("pc load longer than one clock");
    AST_RD_TO_WR: assert property ($rose(file_req.rd) |-> s_clear_tail)
        else $error("write not two clocks after read");
    AST_RD_Q3: assert property (file_req.rd |-> quarter == fbx_pkg::Q_PROCESS)
        else $error("read outside process phase");
    AST_WR_PULSE: assert property (file_req.wr |=> !file_req.wr)
        else $error("write longer than one clock");
    AST_QUIET_FLUSH: assert property (flush |-> !file_req.rd && !file_req.wr)
        else $error("file access during idle cycle");
endmodule : fbx_exec_monitor

bind fbx_exec fbx_exec_monitor u_mon (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .quarter(quarter),
    .pc_load(pc_load),
    .file_req(file_req),
    .flush(flush)
);

// *** verification/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
    logic                   core_clk, reset_n, instr_valid, ext_set_enable, pc_load, flush;
    logic [15:0]            instr;
    fbx_pkg::fbx_flags_t    flags;
    logic [3:0]             bank_select_register;
    logic [11:0]            index_base;
    logic [20:0]            pc_incremented, pc_target;
    logic [7:0]             file_rdata, hi;
    logic [1:0]             quarter;
    fbx_pkg::fbx_file_req_t file_req;
    int                     n_mismatch, checked, seed, i, k;
    fbx_exec u_dut (.core_clk(core_clk), .reset_n(reset_n), .instr(instr),
        .instr_valid(instr_valid), .flags(flags), .ext_set_enable(ext_set_enable),
        .bank_select_register(bank_select_register), .index_base(index_base),
        .pc_incremented(pc_incremented), .file_rdata(file_rdata), .quarter(quarter),
        .pc_load(pc_load), .pc_target(pc_target), .file_req(file_req), .flush(flush));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic give_verdict;
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : give_verdict
    function automatic logic exp_taken(input logic [7:0] h);
        case (h)
            8'he6: return flags.negative;
            8'he3: return !flags.carry;
            8'he7: return !flags.negative;
            8'he5: return !flags.overflow;
            default: return 1'b0;
        endcase
    endfunction : exp_taken
    function automatic logic [11:0] exp_addr(input logic [15:0] w);
        if (w[8]) return {bank_select_register, w[7:0]};
        if (ext_set_enable && w[7:0] <= 8'h5f) return index_base + 12'(w[7:0]);
        return {(w[7:0] <= 8'h5f) ? 4'h0 : 4'hf, w[7:0]};
    endfunction : exp_addr
    task automatic slot(input logic [15:0] w, input logic v);
        logic ld, fl, rd, wr, ix, tk, bc;
        logic [20:0] tgt, etgt;
        logic [11:0] ad;
        logic [7:0] wd;
        {ld, fl, rd, wr, ix, tgt, ad, wd} = '0;
        do @(negedge core_clk); while (quarter !== 2'h3);
        @(posedge core_clk);
        instr <= w;
        instr_valid <= v;
        flags <= 3'($random(seed));
        ext_set_enable <= 1'($random(seed));
        bank_select_register <= 4'($random(seed));
        index_base <= 12'($random(seed));
        pc_incremented <= 21'($random(seed));
        file_rdata <= 8'($random(seed));
        @(posedge core_clk);
        instr_valid <= 1'b0;
        tk = v && exp_taken(w[15:8]);
        bc = v && w[15:12] == 4'h9;
        etgt = pc_incremented + {{12{w[7]}}, w[7:0], 1'b0};
        for (int j = 1; j <= 10; j++) begin
            @(negedge core_clk);
            if (pc_load === 1'b1) {ld, tgt} = {1'b1, pc_target};
            if (flush === 1'b1) fl = 1'b1;
            if (file_req.rd === 1'b1) rd = 1'b1;
            if (file_req.wr === 1'b1) {wr, wd, ad, ix} = {1'b1, file_req.wdata,
                file_req.addr, file_req.indexed};
            // Bit clear offered in the idle cycle must be ignored
            if (j == 4 && tk) {instr, instr_valid} <= {16'h9000, 1'b1};
            if (j == 5) instr_valid <= 1'b0;
        end
        chk("pc_load", 32'(tk), 32'(ld));
        chk("flush", 32'(tk), 32'(fl));
        if (tk) chk("pc_target", 32'(etgt), 32'(tgt));
        chk("read", 32'(bc), 32'(rd));
        chk("write", 32'(bc), 32'(wr));
        if (bc) begin
            chk("wdata", 32'(file_rdata & ~(8'h01 << w[11:9])), 32'(wd));
            chk("addr", 32'(exp_addr(w)), 32'(ad));
            chk("indexed", 32'(!w[8] && ext_set_enable && w[7:0] <= 8'h5f), 32'(ix));
        end
    endtask : slot
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        #200000;
        n_mismatch++;
        give_verdict();
    end
    initial begin
        {reset_n, instr_valid, ext_set_enable, instr, flags, bank_select_register} = '0;
        {index_base, pc_incremented, file_rdata, n_mismatch, checked} = '0;
        seed = 39202;
        repeat (20) @(posedge core_clk);
        reset_n <= 1'b1;
        // Offset extremes, indexed boundary, banked, invalid, foreign opcode
        slot(16'he680, 1'b1);
        slot(16'he57f, 1'b1);
        slot(16'h9e5f, 1'b1);
        slot(16'h9060, 1'b1);
        slot(16'h9360, 1'b1);
        slot(16'he7ff, 1'b0);
        slot(16'he212, 1'b1);
        for (i = 0; i < 150; i++) begin
            k = {$random(seed)} % 6;
            hi = (k == 4) ? {4'h9, 4'($random(seed))} : (k == 5) ? 8'(8'he6 >> (k - 4)) :
                8'(k == 0 ? 8'he6 : k == 1 ? 8'he3 : k == 2 ? 8'he7 : 8'he5);
            slot({hi, 8'($random(seed))}, 1'b1);
        end
        give_verdict();
    end
endmodule : tb_top
